// *** rtl/urbs_ent_if.sv ***
// one buffer entry with its valid strobe, passed between receive blocks
// assumes producer and consumer share i_mclk
`timescale 1ns/1ps
interface urbs_ent_if;
	import urbs_pkg::*;
	logic           valid;
	urbs_entry_type entry;
	modport src (output valid, output entry);
	modport dst (input valid, input entry);
endinterface

// *** rtl/urbs_fifo.sv ***
// small receive fifo; entries held in flip-flops
// assumes pop and push may fall in the same cycle; flush overrides both
`timescale 1ns/1ps
module urbs_fifo
	import urbs_pkg::*;
#(
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_flush,
	input  wire logic              i_pop,
	urbs_ent_if.dst                i_push,
	output urbs_pkg::urbs_entry_type o_head,
	output logic [$clog2(DEPTH+1)-1:0] o_count,
	output logic                   o_full
);
	import urbs_pkg::*;

	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CNT_W = $clog2(DEPTH+1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH-1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	urbs_entry_type   mem_ff [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [PTR_W-1:0] rd_ptr_ff, nxt_rd_ptr;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic             do_push;
	logic             do_pop;

	// --------------------------------------------------------------
	// pointers
	// --------------------------------------------------------------
	always_comb begin
		do_push    = i_push.valid && (cnt_ff != CNT_FULL) && !i_flush;
		do_pop     = i_pop && (cnt_ff != '0) && !i_flush;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_cnt    = cnt_ff;
		if (i_flush) begin
			nxt_wr_ptr = '0;
			nxt_rd_ptr = '0;
			nxt_cnt    = '0;
		end else begin
			if (do_push) begin
				nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (do_pop) begin
				nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1; // see RL3
			end
			if (do_push && !do_pop) begin
				nxt_cnt = cnt_ff + 1'b1;
			end else if (do_pop && !do_push) begin
				nxt_cnt = cnt_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff    <= nxt_cnt;
		end
	end

	// --------------------------------------------------------------
	// storage, flags kept beside their data
	// --------------------------------------------------------------
	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		urbs_entry_type nxt_mem;
		always_comb begin
			nxt_mem = mem_ff[g];
			if (do_push && wr_ptr_ff == PTR_W'(g)) begin
				nxt_mem = i_push.entry; // see RL8 RL26
			end
		end
		always_ff @(posedge i_mclk) begin
			if (!i_rst_n) begin
				mem_ff[g] <= '0;
			end else begin
				mem_ff[g] <= nxt_mem;
			end
		end
	end

	assign o_head  = mem_ff[rd_ptr_ff];
	assign o_count = cnt_ff;
	assign o_full  = (cnt_ff == CNT_FULL);

	a_fifo_flush: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RL5
		i_flush |=> (cnt_ff == '0))
		else $error("fifo not empty after flush");
	a_fifo_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RL26
		cnt_ff <= CNT_FULL)
		else $error("fifo count beyond depth");
endmodule

// *** rtl/urbs_frame.sv ***
// frame assembler: collects sampled bits into one buffer entry
// assumes one i_bit_valid pulse per majority-voted bit after i_start
`timescale 1ns/1ps
module urbs_frame
	import urbs_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_abort,
	input  wire logic              i_start,
	input  wire logic              i_bit_valid,
	input  wire logic              i_bit_val,
	input  wire logic [CSZ_W-1:0]  i_char_size,
	input  wire logic              i_par_en,
	input  wire logic              i_par_odd,
	urbs_ent_if.src                o_frm
);
	import urbs_pkg::*;

	urbs_frm_state_type state_ff, nxt_state;
	logic [3:0]         cnt_ff, nxt_cnt;
	logic [3:0]         nbits_ff, nxt_nbits;
	logic [8:0]         data_ff, nxt_data;
	logic               paren_ff, nxt_paren;
	logic               parodd_ff, nxt_parodd;
	logic               par_ff, nxt_par;
	logic               valid_ff, nxt_valid;
	urbs_entry_type     entry_ff, nxt_entry;

	// --------------------------------------------------------------
	// shift stage
	// --------------------------------------------------------------
	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_nbits  = nbits_ff;
		nxt_data   = data_ff;
		nxt_paren  = paren_ff;
		nxt_parodd = parodd_ff;
		nxt_par    = par_ff;
		nxt_valid  = 1'b0;
		nxt_entry  = entry_ff;
		if (i_abort) begin
			nxt_state = FRM_IDLE; // see RL20
		end else if (i_start) begin
			// format latched per frame so a mid-frame change cannot corrupt it
			nxt_state  = FRM_DATA;
			nxt_cnt    = '0;
			nxt_data   = '0;
			nxt_nbits  = urbs_char_bits(i_char_size);
			nxt_paren  = i_par_en; // see RL19
			nxt_parodd = i_par_odd;
		end else if (i_bit_valid) begin
			unique case (state_ff)
				FRM_IDLE: begin
				end
				FRM_DATA: begin
					nxt_data[cnt_ff] = i_bit_val;
					nxt_cnt          = cnt_ff + 4'h1;
					if (cnt_ff == nbits_ff - 4'h1) begin
						nxt_state = paren_ff ? FRM_PAR : FRM_STOP; // see RL17
					end
				end
				FRM_PAR: begin
					nxt_par   = i_bit_val;
					nxt_state = FRM_STOP;
				end
				FRM_STOP: begin
					// later stop bits are never counted
					nxt_state      = FRM_IDLE; // see RL13
					nxt_valid      = 1'b1; // see RL23
					nxt_entry.data = data_ff;
					nxt_entry.fe   = ~i_bit_val; // see RL12
					nxt_entry.overrun_flag  = 1'b0;
					nxt_entry.pe   = paren_ff & (^data_ff ^ par_ff ^ parodd_ff); // see RL18 RL25
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_ff  <= FRM_IDLE;
			cnt_ff    <= '0;
			nbits_ff  <= BITS_EIGHT;
			data_ff   <= '0;
			paren_ff  <= 1'b0;
			parodd_ff <= 1'b0;
			par_ff    <= 1'b0;
			valid_ff  <= 1'b0;
			entry_ff  <= '0;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			nbits_ff  <= nxt_nbits;
			data_ff   <= nxt_data;
			paren_ff  <= nxt_paren;
			parodd_ff <= nxt_parodd;
			par_ff    <= nxt_par;
			valid_ff  <= nxt_valid;
			entry_ff  <= nxt_entry;
		end
	end

	assign o_frm.valid = valid_ff;
	assign o_frm.entry = entry_ff;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	a_fe_first_stop: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RL12
		(state_ff == FRM_STOP && i_bit_valid && !i_abort && !i_start)
		|=> (valid_ff && entry_ff.fe == !$past(i_bit_val)))
		else $error("frame error does not follow first stop bit");
	a_pe_disabled: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RL19
		(valid_ff && !paren_ff) |-> !entry_ff.pe)
		else $error("parity error set with checking off");
	a_abort_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RL20
		i_abort |=> (state_ff == FRM_IDLE && !valid_ff))
		else $error("frame survived receiver disable");
endmodule

// *** rtl/urbs_pkg.sv ***
// receive buffer and status block: constants, entry layout, state type
// assumes one system clock; bit sampling and start detection sit outside
//
// Functional notes
// RL1: with nine-bit characters software reads the ninth bit before the data byte
// RL2: software reads error status before the data byte of the same entry
// RL3: a data register read advances the fifo to the next entry
// RL4: receive-done flag is high exactly while the buffer holds unread entries
// RL5: clearing receiver enable flushes the buffer and drops receive-done
// RL6: done interrupt requested while flag, its enable and global enable are high
// RL7: an interrupt handler reads data to clear the level request
// RL8: frame, overrun and parity flags travel in the fifo with their frame
// RL9: status register writes never change the three error flags
// RL10: software writes zero to error flag positions of the status register
// RL11: error flags never raise an interrupt by themselves
// RL12: frame error is one when the first stop bit sampled low
// RL13: only the first stop bit is checked, whatever stop count is selected
// RL14: overrun when buffer full, frame waiting and a new start arrives
// RL15: overrun set means frames were lost before this entry
// RL16: overrun indication clears once a frame moves into the buffer
// RL17: parity check active only with high mode bit; low bit picks odd/even
// RL18: parity over data bits compared with parity bit, stored with the entry
// RL19: parity error recorded only if enabled at arrival; reads zero when disabled
// RL20: disabling the receiver abandons any frame in progress at once
// RL21: receiver releases the pin override while disabled
// RL22: software drains the buffer by reading data until done reads zero
// RL23: after the first stop bit the frame moves from shift stage to buffer
// RL24: unused upper bits of short characters read as zero
// RL25: low parity bit zero means even, one means odd
// RL26: buffer is a two-entry fifo of data, ninth bit and three flags
package urbs_pkg;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam int unsigned ADDR_W     = 2;
	localparam int unsigned DATA_W     = 8;
	localparam logic [1:0]  REG_STATUS = 2'h0;
	localparam logic [1:0]  REG_CTRL   = 2'h1;
	localparam logic [1:0]  REG_FORMAT = 2'h2;
	localparam logic [1:0]  REG_DATA   = 2'h3;

	localparam int unsigned ST_DONE_BIT  = 7;
	localparam int unsigned ST_FE_BIT    = 4;
	localparam int unsigned ST_DOR_BIT   = 3;
	localparam int unsigned ST_PE_BIT    = 2;
	localparam int unsigned CT_IRQEN_BIT = 7;
	localparam int unsigned CT_RECEIVER_ENABLE_BIT  = 4;
	localparam int unsigned CT_RX9_BIT   = 1;
	localparam int unsigned CT_TX9_BIT   = 0;
	localparam int unsigned FM_PMHI_BIT  = 5;
	localparam int unsigned FM_PMLO_BIT  = 4;
	localparam int unsigned FM_STOP_BIT  = 3;
	localparam int unsigned FM_CSZ_LSB   = 0;
	localparam int unsigned CSZ_W        = 3;

	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] FMT_RST    = 8'h03;
	localparam logic [7:0] CTRL_WMASK = 8'h91;
	localparam logic [7:0] FMT_WMASK  = 8'h3f;
	localparam logic [7:0] RDATA_RST  = 8'h00;

	// --------------------------------------------------------------
	// character format
	// --------------------------------------------------------------
	localparam int unsigned CHAR_W     = 9;
	localparam int unsigned FIFO_DEPTH = 2;
	localparam logic [2:0]  CSZ_NINE   = 3'h7;
	localparam logic [3:0]  BITS_FIVE  = 4'h5;
	localparam logic [3:0]  BITS_SIX   = 4'h6;
	localparam logic [3:0]  BITS_SEVEN = 4'h7;
	localparam logic [3:0]  BITS_EIGHT = 4'h8;
	localparam logic [3:0]  BITS_NINE  = 4'h9;
	localparam logic [8:0]  CHAR_ONES  = 9'h1ff;

	typedef struct packed {
		logic [CHAR_W-1:0] data;
		logic              fe;
		logic              overrun_flag;
		logic              pe;
	} urbs_entry_type;

	typedef enum logic [1:0] {FRM_IDLE, FRM_DATA, FRM_PAR, FRM_STOP} urbs_frm_state_type;

	// reserved size codes fall back to eight bits
	function automatic logic [3:0] urbs_char_bits(input logic [2:0] csz);
		unique case (csz)
			3'h0:     return BITS_FIVE;
			3'h1:     return BITS_SIX;
			3'h2:     return BITS_SEVEN;
			CSZ_NINE: return BITS_NINE;
			default:  return BITS_EIGHT;
		endcase
	endfunction

	function automatic logic [8:0] urbs_char_mask(input logic [2:0] csz);
		return ~(CHAR_ONES << urbs_char_bits(csz));
	endfunction

endpackage

// *** rtl/urbs_rx_top.sv ***
// receive buffer and status top: registers, hold stage, overrun, interrupt
// assumes start detection and voted bits arrive synchronous to i_mclk
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module urbs_rx_top
	import urbs_pkg::*;
(
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst_n,
	input  wire logic [urbs_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [urbs_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [urbs_pkg::DATA_W-1:0] o_rdata,
	input  wire logic                        i_start_det,
	input  wire logic                        i_bit_valid,
	input  wire logic                        i_bit_val,
	input  wire logic                        i_global_irq_en,
	output logic                             o_rx_done_irq,
	output logic                             o_rx_pin_override
);
	import urbs_pkg::*;

	localparam int unsigned CNT_W = $clog2(FIFO_DEPTH+1);

	logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
	logic [DATA_W-1:0] fmt_ff, nxt_fmt;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic              irq_ff, nxt_irq;
	logic              ovr_ff, nxt_ovr;
	logic              pend_valid_ff, nxt_pend_valid;
	urbs_entry_type    pend_ff, nxt_pend;
	logic              dor_lost_ff, nxt_dor_lost;

	urbs_entry_type    head;
	logic [CNT_W-1:0]  fifo_count;
	logic              fifo_full;
	logic              rx_en;
	logic              rx_done;
	logic              pop;
	logic              push;
	logic [8:0]        char_mask;
	logic              par_en;
	logic [DATA_W-1:0] rd_val;

	urbs_ent_if frm_if ();
	urbs_ent_if push_if ();

	assign rx_en     = ctrl_ff[CT_RECEIVER_ENABLE_BIT];
	assign rx_done   = (fifo_count != '0); // see RL4
	assign pop       = i_rd && (i_addr == REG_DATA) && rx_en;
	assign push      = pend_valid_ff && !fifo_full && rx_en;
	assign par_en    = fmt_ff[FM_PMHI_BIT];
	assign char_mask = urbs_char_mask(fmt_ff[FM_CSZ_LSB +: CSZ_W]);

	// --------------------------------------------------------------
	// frame assembly and buffer
	// --------------------------------------------------------------
	urbs_frame u_frame (
		.i_mclk      (i_mclk),
		.i_rst_n     (i_rst_n),
		.i_abort     (!rx_en),
		.i_start     (i_start_det),
		.i_bit_valid (i_bit_valid),
		.i_bit_val   (i_bit_val),
		.i_char_size (fmt_ff[FM_CSZ_LSB +: CSZ_W]),
		.i_par_en    (par_en),
		.i_par_odd   (fmt_ff[FM_PMLO_BIT]),
		.o_frm       (frm_if)
	);

	assign push_if.valid      = push;
	// one driver for the whole entry; overrun comes from the tracker, not the frame
	assign push_if.entry = '{
		data: pend_ff.data,
		fe:   pend_ff.fe,
		overrun_flag:  dor_lost_ff, // see RL15
		pe:   pend_ff.pe
	};

	urbs_fifo #(
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_flush (!rx_en), // see RL5
		.i_pop   (pop), // see RL3
		.i_push  (push_if),
		.o_head  (head),
		.o_count (fifo_count),
		.o_full  (fifo_full)
	);

	// --------------------------------------------------------------
	// hold stage and overrun tracking
	// --------------------------------------------------------------
	always_comb begin
		nxt_pend_valid = pend_valid_ff;
		nxt_pend       = pend_ff;
		nxt_dor_lost   = dor_lost_ff;
		if (!rx_en) begin
			nxt_pend_valid = 1'b0;
			nxt_dor_lost   = 1'b0;
		end else begin
			if (push) begin
				nxt_pend_valid = 1'b0;
				nxt_dor_lost   = 1'b0; // see RL16
			end
			// a full buffer plus a waiting frame, with no data read in that cycle, means a new start loses the waiting one
			if (i_start_det && fifo_full && pend_valid_ff && !pop) begin
				nxt_dor_lost = 1'b1; // see RL14
			end
			if (frm_if.valid) begin
				nxt_pend_valid = 1'b1; // see RL23
				nxt_pend       = frm_if.entry;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pend_valid_ff <= 1'b0;
			pend_ff       <= '0;
			dor_lost_ff   <= 1'b0;
		end else begin
			pend_valid_ff <= nxt_pend_valid;
			pend_ff       <= nxt_pend;
			dor_lost_ff   <= nxt_dor_lost;
		end
	end

	// --------------------------------------------------------------
	// register port
	// --------------------------------------------------------------
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_fmt  = fmt_ff;
		// status writes carry no writable bits, so the error flags stay put
		if (i_wr && i_addr == REG_CTRL) begin
			nxt_ctrl = i_wdata & CTRL_WMASK;
		end
		if (i_wr && i_addr == REG_FORMAT) begin
			nxt_fmt = i_wdata & FMT_WMASK;
		end
	end

	always_comb begin
		rd_val = '0;
		unique case (i_addr)
			REG_STATUS: begin
				rd_val[ST_DONE_BIT] = rx_done;
				rd_val[ST_FE_BIT]   = head.fe && rx_done; // see RL9
				rd_val[ST_DOR_BIT]  = head.overrun_flag && rx_done;
				rd_val[ST_PE_BIT]   = head.pe && rx_done && par_en; // see RL19
			end
			REG_CTRL: begin
				rd_val             = ctrl_ff;
				rd_val[CT_RX9_BIT] = head.data[CHAR_W-1] && rx_done;
			end
			REG_FORMAT: begin
				rd_val = fmt_ff;
			end
			REG_DATA: begin
				rd_val = head.data[DATA_W-1:0] & char_mask[DATA_W-1:0]; // see RL24
			end
		endcase
		nxt_rdata = i_rd ? rd_val : RDATA_RST;
	end

	// --------------------------------------------------------------
	// interrupt request and pin override
	// --------------------------------------------------------------
	always_comb begin
		// only the done flag feeds the request; error flags stay out of it
		nxt_irq = rx_done && ctrl_ff[CT_IRQEN_BIT] && i_global_irq_en; // see RL6 RL11
		nxt_ovr = rx_en; // see RL21
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ctrl_ff  <= CTRL_RST;
			fmt_ff   <= FMT_RST;
			rdata_ff <= RDATA_RST;
			irq_ff   <= 1'b0;
			ovr_ff   <= 1'b0;
		end else begin
			ctrl_ff  <= nxt_ctrl;
			fmt_ff   <= nxt_fmt;
			rdata_ff <= nxt_rdata;
			irq_ff   <= nxt_irq;
			ovr_ff   <= nxt_ovr;
		end
	end

	assign o_rdata           = rdata_ff;
	assign o_rx_done_irq     = irq_ff;
	assign o_rx_pin_override = ovr_ff;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	sequence s_data_read;
		i_rd && i_addr == REG_DATA;
	endsequence

	sequence s_status_read;
		i_rd && i_addr == REG_STATUS;
	endsequence

	a_pop_advance: assert property ( // see RL3
		(s_data_read and (rx_en && rx_done && !push))
		|=> (fifo_count == $past(fifo_count) - 1'b1))
		else $error("data read did not advance fifo");
	a_irq_follows: assert property ( // see RL6
		(rx_done && ctrl_ff[CT_IRQEN_BIT] && i_global_irq_en) |=> o_rx_done_irq)
		else $error("done request missing");
	a_irq_no_err: assert property ( // see RL11
		!rx_done |=> !o_rx_done_irq)
		else $error("request without done flag");
	a_disable_flush: assert property ( // see RL5
		!rx_en ##1 !rx_en |-> !rx_done)
		else $error("buffer not flushed while disabled");
	a_pe_gated_read: assert property ( // see RL19
		(s_status_read and !par_en) |=> !o_rdata[ST_PE_BIT])
		else $error("parity error read with checking off");
	a_short_mask: assert property ( // see RL24
		s_data_read |=> ((o_rdata & ~$past(char_mask[DATA_W-1:0])) == '0))
		else $error("unused data bits not zero");
	a_dor_clears: assert property ( // see RL16
		(push && !i_start_det) |=> !dor_lost_ff)
		else $error("overrun not cleared after transfer");
	a_override_off: assert property ( // see RL21
		!rx_en |=> !o_rx_pin_override)
		else $error("pin still overridden while disabled");
	a_rdata_idle: assert property ( // see RL9
		!i_rd |=> (o_rdata == RDATA_RST))
		else $error("read data outside read cycle");
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the receive buffer and status block
// assumes the transmitter model feeds voted bits; one clock domain
`timescale 1ns/1ps
module testbench;
	import urbs_pkg::*;
	logic              i_mclk;
	logic              i_rst_n;
	logic              i_wr;
	logic              i_rd;
	logic              i_global_irq_en;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic [DATA_W-1:0] o_rdata;
	logic              o_rx_done_irq;
	logic              o_rx_pin_override;
	logic              st_det;
	logic              b_vld;
	logic              b_val;
	int                miscompares = 0;
	int                comparisons = 0;

	urbs_rx_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_start_det(st_det), .i_bit_valid(b_vld), .i_bit_val(b_val),
		.i_global_irq_en(i_global_irq_en), .o_rx_done_irq(o_rx_done_irq),
		.o_rx_pin_override(o_rx_pin_override));
	urbs_tx_model tx (.i_mclk(i_mclk), .o_start(st_det), .o_bit_valid(b_vld),
		.o_bit_val(b_val));

	always #20 i_mclk = ~i_mclk;

	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask

	// entry reaches the fifo two cycles after the stop bit, irq one later
	task automatic rx(input logic [8:0] d, input int n, input logic np,
		input logic pb, input logic stp, input int gap);
		tx.send(d, n, np, pb, stp, gap);
		repeat (4) @(posedge i_mclk);
		#1;
	endtask

	task automatic finish_test;
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		chk(o_rx_pin_override, 1'b0);
		rd(REG_CTRL, CTRL_RST);
		rd(REG_FORMAT, FMT_RST);
		rd(REG_STATUS, 8'h00);
	endtask

	task automatic t_basic;
		wr(REG_CTRL, 8'h10);
		@(posedge i_mclk);
		#1 chk(o_rx_pin_override, 1'b1);
		rx(9'h0a5, 8, 0, 0, 1, 2);
		rd(REG_STATUS, 8'h80);
		rd(REG_DATA, 8'ha5);
		rd(REG_STATUS, 8'h00);
	endtask

	// third frame waits in the hold stage, fourth start loses it
	task automatic t_overrun;
		rx(9'h011, 8, 0, 0, 1, 0);
		rx(9'h022, 8, 0, 0, 0, 1);
		rx(9'h033, 8, 0, 0, 1, 0);
		rx(9'h044, 8, 0, 0, 1, 0);
		rd(REG_STATUS, 8'h80);
		rd(REG_DATA, 8'h11);
		wr(REG_STATUS, 8'h00);
		rd(REG_STATUS, 8'h90);
		rd(REG_DATA, 8'h22);
		rd(REG_STATUS, 8'h88);
		rd(REG_DATA, 8'h44);
		rd(REG_STATUS, 8'h00);
		rx(9'h055, 8, 0, 0, 1, 0);
		rd(REG_STATUS, 8'h80);
		rd(REG_DATA, 8'h55);
	endtask

	task automatic t_parity;
		logic [7:0] d;
		int         o;
		int         e;
		d = 8'h5b;
		for (o = 0; o < 2; o++) begin
			for (e = 0; e < 2; e++) begin
				wr(REG_FORMAT, 8'h23 | 8'(o << FM_PMLO_BIT));
				rx(d, 8, 1, ^d ^ o[0] ^ e[0], 1, 0);
				rd(REG_STATUS, e[0] ? 8'h84 : 8'h80);
				rd(REG_DATA, d);
			end
		end
		// low mode bit alone leaves the checker off
		wr(REG_FORMAT, 8'h13);
		rx(d, 8, 0, 0, 1, 0);
		rd(REG_STATUS, 8'h80);
		rd(REG_DATA, d);
	endtask

	task automatic t_sizes;
		wr(REG_FORMAT, 8'h00);
		rx(9'h015, 5, 0, 0, 1, 0);
		rd(REG_DATA, 8'h15);
		wr(REG_FORMAT, 8'h0f);
		rx(9'h1a5, 9, 0, 0, 0, 0);
		rd(REG_STATUS, 8'h90);
		rd(REG_CTRL, 8'h12);
		rd(REG_DATA, 8'ha5);
		rd(REG_CTRL, 8'h10);
		wr(REG_FORMAT, FMT_RST);
	endtask

	task automatic t_irq;
		wr(REG_CTRL, 8'h90);
		@(posedge i_mclk);
		i_global_irq_en <= 1'b1;
		rx(9'h066, 8, 0, 0, 0, 0);
		chk(o_rx_done_irq, 1'b1);
		@(posedge i_mclk);
		i_global_irq_en <= 1'b0;
		@(posedge i_mclk);
		#1 chk(o_rx_done_irq, 1'b0);
		@(posedge i_mclk);
		i_global_irq_en <= 1'b1;
		rd(REG_DATA, 8'h66);
		@(posedge i_mclk);
		#1 chk(o_rx_done_irq, 1'b0);
	endtask

	// disable in mid-frame, re-enable before the stop bit arrives
	task automatic t_disable;
		wr(REG_CTRL, 8'h10);
		rx(9'h077, 8, 0, 0, 1, 0);
		rx(9'h088, 8, 0, 0, 1, 0);
		fork
			tx.send(9'h099, 8, 0, 0, 1, 3);
			begin
				repeat (6) @(posedge i_mclk);
				wr(REG_CTRL, 8'h00);
				@(posedge i_mclk);
				#1 chk(o_rx_pin_override, 1'b0);
				rd(REG_STATUS, 8'h00);
				wr(REG_CTRL, 8'h10);
			end
		join
		repeat (4) @(posedge i_mclk);
		rd(REG_STATUS, 8'h00);
	endtask

	initial begin
		i_mclk = 1'b0;
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_global_irq_en = 1'b0;
		repeat (4) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset;
		t_basic;
		t_overrun;
		t_parity;
		t_sizes;
		t_irq;
		t_disable;
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		finish_test;
	end
endmodule

// *** verif/urbs_tx_model.sv ***
// remote transmitter model: drives the voted bit stream of one frame
// assumes the bench calls send from a process running on i_mclk
`timescale 1ns/1ps
module urbs_tx_model (
	input  wire logic i_mclk,
	output logic      o_start,
	output logic      o_bit_valid,
	output logic      o_bit_val
);
	// ------------------------------------------------------------
	// frame driver
	// ------------------------------------------------------------
	initial begin
		o_start = 1'b0;
		o_bit_valid = 1'b0;
		o_bit_val = 1'b1;
	end

	// between bits the line shows the inverse, so stale values never match
	task automatic send(input logic [8:0] d, input int n, input logic np,
		input logic pb, input logic stp, input int gap);
		int   k;
		logic v;
		@(posedge i_mclk);
		o_start <= 1'b1;
		for (k = 0; k <= n + np; k++) begin
			@(posedge i_mclk);
			o_start <= 1'b0;
			v = (k < n) ? d[k] : ((k == n && np) ? pb : stp);
			o_bit_valid <= 1'b1;
			o_bit_val <= v;
			repeat (gap) begin
				@(posedge i_mclk);
				o_bit_valid <= 1'b0;
				o_bit_val <= ~v;
			end
		end
		@(posedge i_mclk);
		o_bit_valid <= 1'b0;
		o_bit_val <= ~v;
	endtask
endmodule
